// file: design/cal_pkg.sv
// constants shared by the converter control end and the host end
// assumes a single master clock mclk at 40 MHz on both ends
package cal_pkg;
	localparam int MCLK_HZ         = 40000000;
	// modulator cycle and output period as multiples of mclk
	localparam int MOD_DIV         = 256;
	localparam int OUT_DIV_DEF     = 2048;
	localparam int ACC_W           = 33;
	localparam int COEF_W          = 24;
	localparam int RAW_W           = 24;
	// calibration durations in output periods
	localparam int SELF_PERIODS    = 9;
	localparam int SYS_PERIODS     = 4;
	localparam int BG_RATE_DIV     = 6;
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_SELF   = 3'h1;
	localparam logic [2:0] MODE_SYS_ZS = 3'h2;
	localparam logic [2:0] MODE_SYS_FS = 3'h3;
	localparam logic [2:0] MODE_SYS_OF = 3'h4;
	localparam logic [2:0] MODE_BG     = 3'h5;
	localparam logic [23:0] OFFSET_RST = 24'h000000;
	localparam logic [23:0] GAIN_RST   = 24'h400000;
	localparam logic [23:0] MIDSCALE   = 24'h800000;
	localparam logic [23:0] FULLSCALE  = 24'hFFFFFF;
	localparam int GAIN_SHIFT      = 22;
endpackage

// file: design/cal_if.sv
// link between host controller and converter control end
// assumes both ends run on the same mclk
`timescale 1ns/100ps
interface cal_if;
	logic [2:0]  cal_mode_field;
	logic        mode_write;
	logic        sync_n;
	logic        coef_write;
	logic [23:0] offset_coef_in;
	logic [23:0] gain_coef_in;
	logic        conversion_done_n;
	logic [23:0] result;
	modport device (input cal_mode_field, mode_write, sync_n, coef_write, offset_coef_in, gain_coef_in,
		output conversion_done_n, result);
	modport host (output cal_mode_field, mode_write, sync_n, coef_write, offset_coef_in, gain_coef_in,
		input conversion_done_n, result);
endinterface

// file: design/cal_device.sv
// converter calibration and sync control end
// assumes raw modulator-filter samples arrive on analog_input, taken every mclk with no strobe
//
// Contract
// - all rates and durations counted from mclk
// - sync falling edge resets filter state
// - any calibration command resets filter
// - subtract offset, then multiply by gain
// - 33-bit internal math, 16/24-bit output
// - host may write both coefficients
// - ready goes low when calibration completes
// - ready may take one modulator cycle high
// - host ignores ready one modulator cycle
// - mode 001 starts self-calibration
// - self-cal: zero node, reference, then resettle
// - self-cal uses current gain setting
// - bipolar self-cal uses midscale and full
// - mode 010 runs system zero step
// - host holds zero input during step
// - mode 011 runs system full step
// - host holds full input during step
// - system cal endpoints follow polarity range
// - lone zero step keeps the slope
// - host recalibrates after range changes
// - mode 100 runs system offset calibration
// - mode 101 interleaves, rate divided six
`timescale 1ns/100ps
module cal_device #(
	parameter int OUT_DIV = cal_pkg::OUT_DIV_DEF
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        clk_en,
	// host link
	cal_if.device            link,
	// converter user side
	input  wire logic [23:0] analog_input,
	input  wire logic [23:0] ref_sample,
	input  wire logic [23:0] zero_sample,
	input  wire logic        bipolar,
	input  wire logic        word24,
	input  wire logic [2:0]  gain_sel,
	output logic             sel_zero_node,
	output logic             sel_ref_node,
	output logic [2:0]       cal_gain,
	output logic [23:0]      offset_coef,
	output logic [23:0]      gain_coef
);
	typedef enum logic [2:0] {
		ST_RUN   = 3'b000,
		ST_ZERO  = 3'b001,
		ST_FULL  = 3'b010,
		ST_SETL  = 3'b011,
		ST_DONE  = 3'b100
	} state_t;

	state_t       state;
	state_t       next_state;
	logic [2:0]   mode;
	logic         sync_q;
	logic [15:0]  out_cnt;
	logic [3:0]   period_cnt;
	logic [7:0]   mod_cnt;
	logic         ready_n;
	logic         busy_hold;
	logic         fresh;
	logic [2:0]   bg_cnt;
	logic [23:0]  zero_meas;
	logic [23:0]  result;

	wire        out_tick  = (out_cnt == 16'(OUT_DIV - 1));
	wire        mod_tick  = (mod_cnt == 8'(cal_pkg::MOD_DIV - 1));
	wire        sync_fall = sync_q & ~link.sync_n;
	wire        cmd       = link.mode_write && link.cal_mode_field != cal_pkg::MODE_NORMAL;
	wire [2:0]  wmode     = link.cal_mode_field;
	wire [23:0] zero_pt   = bipolar ? cal_pkg::MIDSCALE : 24'h000000;
	wire [23:0] zsrc      = (mode == cal_pkg::MODE_SYS_ZS || mode == cal_pkg::MODE_SYS_OF) ? analog_input : zero_sample;
	wire [23:0] fsrc      = (mode == cal_pkg::MODE_SYS_FS) ? analog_input : ref_sample;
	// span measured from zero_meas, the stored zero step reading
	wire [24:0] span      = {1'b0, fsrc} - {1'b0, zero_meas};
	wire [24:0] ideal     = {1'b0, cal_pkg::FULLSCALE} - {1'b0, zero_pt};
	wire [47:0] gnum      = {ideal[23:0], 24'h000000} >> (24 - cal_pkg::GAIN_SHIFT);
	wire [23:0] new_gain  = (span[23:0] == 24'h000000) ? gain_coef : 24'(gnum / {24'h000000, span[23:0]});
	wire [32:0] diff      = 33'($signed({1'b0, analog_input}) - $signed({1'b0, offset_coef}));
	wire [56:0] prod      = 57'($signed(diff) * $signed({1'b0, gain_coef}));
	// zero point added after scaling so bipolar zero reads midscale
	wire [32:0] scaled    = 33'(prod >>> cal_pkg::GAIN_SHIFT) + 33'({9'h000, zero_pt});
	wire [23:0] sat       = scaled[32] ? 24'h000000 : (|scaled[31:24] ? cal_pkg::FULLSCALE : scaled[23:0]);
	wire [23:0] fmt       = word24 ? sat : {sat[23:8], 8'h00};
	wire        steps_end = out_tick && period_cnt == 4'h0;
	wire        one_step  = (mode != cal_pkg::MODE_SYS_ZS && mode != cal_pkg::MODE_SYS_FS);
	// background mode hands out one word in six periods
	wire        emit      = state == ST_RUN && out_tick && !busy_hold && !cmd
				&& (mode != cal_pkg::MODE_BG || bg_cnt == 3'(cal_pkg::BG_RATE_DIV - 1));

	always_comb begin
		next_state = state;
		unique case (state)
			ST_RUN:  next_state = (mode == cal_pkg::MODE_BG && bg_cnt == 3'(cal_pkg::BG_RATE_DIV - 1) && out_tick)
					? ST_ZERO : ST_RUN;
			ST_ZERO: if (steps_end) begin
				next_state = (mode == cal_pkg::MODE_SYS_ZS) ? ST_SETL : ST_FULL;
			end
			ST_FULL: if (steps_end) begin
				next_state = ST_SETL;
			end
			ST_SETL: if (steps_end) begin
				next_state = ST_DONE;
			end
			ST_DONE: next_state = ST_RUN;
			default: next_state = ST_RUN;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sync_q  <= 1'b1;
			out_cnt <= 16'h0000;
			mod_cnt <= 8'h00;
		end else if (clk_en) begin
			sync_q  <= link.sync_n;
			mod_cnt <= mod_cnt + 8'h01;
			if (sync_fall || cmd || out_tick)
				out_cnt <= 16'h0000;
			else
				out_cnt <= out_cnt + 16'h0001;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state      <= ST_RUN;
			mode       <= cal_pkg::MODE_NORMAL;
			period_cnt <= 4'h0;
			bg_cnt     <= 3'h0;
		end else if (clk_en) begin
			if (cmd) begin
				mode       <= wmode;
				state      <= (wmode == cal_pkg::MODE_SYS_FS) ? ST_FULL : ST_ZERO;
				bg_cnt     <= 3'h0;
				period_cnt <= (wmode == cal_pkg::MODE_SYS_ZS || wmode == cal_pkg::MODE_SYS_FS)
					? 4'(cal_pkg::SYS_PERIODS / 2 - 1) : 4'(cal_pkg::SELF_PERIODS / 3 - 1);
			end else begin
				if (link.mode_write)
					mode <= wmode;
				state <= next_state;
				// one calibration slot every six periods
				// slot periods count too, so the word rate is exactly one in six
				if (mode == cal_pkg::MODE_BG && out_tick)
					bg_cnt <= (bg_cnt == 3'(cal_pkg::BG_RATE_DIV - 1)) ? 3'h0 : bg_cnt + 3'h1;
				if (state != next_state)
					period_cnt <= (mode == cal_pkg::MODE_BG) ? 4'h0
						: (one_step ? 4'(cal_pkg::SELF_PERIODS / 3 - 1) : 4'(cal_pkg::SYS_PERIODS / 2 - 1));
				else if (out_tick && period_cnt != 4'h0)
					period_cnt <= period_cnt - 4'h1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			offset_coef <= cal_pkg::OFFSET_RST;
			gain_coef   <= cal_pkg::GAIN_RST;
			zero_meas   <= 24'h000000;
		end else if (clk_en) begin
			if (link.coef_write) begin
				offset_coef <= link.offset_coef_in;
				gain_coef   <= link.gain_coef_in;
			end else if (state == ST_ZERO && steps_end) begin
				zero_meas   <= zsrc;
				offset_coef <= zsrc;
			end else if (state == ST_FULL && steps_end) begin
				gain_coef   <= new_gain;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ready_n   <= 1'b1;
			busy_hold <= 1'b0;
			fresh     <= 1'b0;
			result    <= 24'h000000;
		end else if (clk_en) begin
			fresh <= emit;
			if (cmd && !mod_tick)
				busy_hold <= 1'b1;
			else if (mod_tick)
				busy_hold <= 1'b0;
			if ((cmd || busy_hold) && mod_tick)
				ready_n <= 1'b1;
			else if (state == ST_DONE && mode != cal_pkg::MODE_BG)
				ready_n <= 1'b0;
			// normal conversions resume
			// high one cycle so every new word gives a fresh falling edge
			else if (emit) begin
				result  <= fmt;
				ready_n <= 1'b1;
			end else if (fresh)
				ready_n <= 1'b0;
		end
	end

	assign sel_zero_node = state == ST_ZERO && (mode == cal_pkg::MODE_SELF || mode == cal_pkg::MODE_BG);
	assign sel_ref_node  = state == ST_FULL && one_step;
	assign cal_gain      = gain_sel;
	assign link.conversion_done_n = ready_n;
	assign link.result   = result;
endmodule

// file: design/cal_host.sv
// host controller end: issues calibration modes, sync and coefficient loads
// assumes the device end on the same mclk through cal_if
`timescale 1ns/100ps
module cal_host (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        clk_en,
	// host link
	cal_if.host              link,
	// user side
	input  wire logic        start,
	input  wire logic [2:0]  mode_in,
	input  wire logic        sync_req,
	input  wire logic        load_req,
	input  wire logic [23:0] offset_in,
	input  wire logic [23:0] gain_in,
	output logic             busy,
	output logic             cal_done,
	output logic [23:0]      data_out,
	output logic             data_valid
);
	logic [7:0] ign_cnt;
	logic [2:0] mode_q;
	logic       wr_q;
	logic       sync_n_q;
	logic       ld_q;
	logic       done_q;
	logic [23:0] off_q;
	logic [23:0] gn_q;

	wire issue = start && !busy;
	// edge, not level: ready stays low between words
	wire done_fall = done_q && !link.conversion_done_n;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ign_cnt    <= 8'h00;
			busy       <= 1'b0;
			mode_q     <= cal_pkg::MODE_NORMAL;
			wr_q       <= 1'b0;
			sync_n_q   <= 1'b1;
			ld_q       <= 1'b0;
			done_q     <= 1'b1;
			off_q      <= 24'h000000;
			gn_q       <= 24'h000000;
			cal_done   <= 1'b0;
			data_out   <= 24'h000000;
			data_valid <= 1'b0;
		end else if (clk_en) begin
			wr_q       <= issue;
			sync_n_q   <= ~sync_req;
			ld_q       <= load_req;
			done_q     <= link.conversion_done_n;
			cal_done   <= 1'b0;
			data_valid <= 1'b0;
			if (load_req) begin
				off_q <= offset_in;
				gn_q  <= gain_in;
			end
			if (issue) begin
				mode_q  <= mode_in;
				busy    <= mode_in != cal_pkg::MODE_NORMAL && mode_in != cal_pkg::MODE_BG;
				ign_cnt <= 8'(cal_pkg::MOD_DIV - 1);
			end else if (ign_cnt != 8'h00)
				ign_cnt <= ign_cnt - 8'h01;
			else if (done_fall) begin
				if (busy) begin
					busy     <= 1'b0;
					cal_done <= 1'b1;
				end else begin
					data_out   <= link.result;
					data_valid <= 1'b1;
				end
			end
		end
	end

	// user holds input stable while busy
	assign link.cal_mode_field = mode_q;
	assign link.mode_write     = wr_q;
	assign link.sync_n         = sync_n_q;
	assign link.coef_write     = ld_q;
	assign link.offset_coef_in = off_q;
	assign link.gain_coef_in   = gn_q;
endmodule

// file: tb/cal_link_asserts.sv
// assertions on the host-device calibration link
// assumes link signals sampled on the shared mclk, rstn
`timescale 1ns/100ps
module cal_link_asserts #(
	parameter int OUT_DIV = cal_pkg::OUT_DIV_DEF
) (
	// clock and reset
	input wire logic        mclk,
	input wire logic        rstn,
	// link signals
	input wire logic [2:0]  cal_mode_field,
	input wire logic        mode_write,
	input wire logic        coef_write,
	input wire logic        sync_n,
	input wire logic        conversion_done_n,
	input wire logic [23:0] result
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	logic        armed;
	logic [11:0] hi_cnt;
	// background mode never completes, so it is left out of the timing
	wire         one_shot = cal_mode_field != cal_pkg::MODE_BG;
	wire         cmd      = mode_write && cal_mode_field != cal_pkg::MODE_NORMAL;
	sequence s_cmd;
		cmd;
	endsequence
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			armed  <= 1'b0;
			hi_cnt <= 12'h000;
		end else begin
			armed  <= (cmd && one_shot) || (armed && !$fell(conversion_done_n));
			hi_cnt <= armed ? hi_cnt + 12'h001 : 12'h000;
		end
	end
	chk_ready_rise: assert property (s_cmd |-> ##[1:256] conversion_done_n)
		else $error("ready not raised after command");
	chk_ready_hold: assert property ($rose(conversion_done_n) && armed |-> conversion_done_n[*8])
		else $error("ready dropped too early");
	chk_done_stands: assert property ($rose(conversion_done_n) && !armed && !mode_write && one_shot
		|=> !conversion_done_n) else $error("word ready pulse longer than one cycle");
	chk_cal_bound: assert property (hi_cnt < 12'h7D0)
		else $error("calibration never completed");
	chk_cal_min: assert property ($fell(conversion_done_n) && armed |-> hi_cnt >= 2 * OUT_DIV)
		else $error("calibration shorter than output periods");
	chk_mode_space: assert property (mode_write |=> !mode_write[*8])
		else $error("commands too close");
	chk_coef_pulse: assert property (coef_write |=> !coef_write)
		else $error("coefficient write not a pulse");
	chk_result_hold: assert property ($changed(result) |=> $stable(result)[*8])
		else $error("result changed between ticks");
endmodule

// file: tb/adc_calibration_sync_control_bench.sv
// bench joining host and converter ends through cal_if
// assumes a shortened output period to keep runs short
`timescale 1ns/100ps
module adc_calibration_sync_control_bench;
	localparam int OD = 128;
	logic        mclk, rstn, start, sync_req, load_req, bipolar, word24;
	logic        cal_done, data_valid, sel_zero_node, sel_ref_node, saw_z, saw_r, saw_h, busy;
	logic [2:0]  mode_in, gain_sel, cal_gain;
	logic [23:0] offset_in, gain_in, analog_input, ref_sample, zero_sample;
	logic [23:0] offset_coef, gain_coef, data_out, g;
	int          fails, num_checks, n;
	cal_if link();
	cal_device #(.OUT_DIV(OD)) cal_device_i (.mclk(mclk), .rstn(rstn), .clk_en(1'b1), .link(link),
		.analog_input(analog_input), .ref_sample(ref_sample), .zero_sample(zero_sample), .bipolar(bipolar),
		.word24(word24), .gain_sel(gain_sel), .sel_zero_node(sel_zero_node), .sel_ref_node(sel_ref_node),
		.cal_gain(cal_gain), .offset_coef(offset_coef), .gain_coef(gain_coef));
	cal_host cal_host_i (.mclk(mclk), .rstn(rstn), .clk_en(1'b1), .link(link), .start(start), .mode_in(mode_in),
		.sync_req(sync_req), .load_req(load_req), .offset_in(offset_in), .gain_in(gain_in), .busy(busy),
		.cal_done(cal_done), .data_out(data_out), .data_valid(data_valid));
	cal_link_asserts #(.OUT_DIV(OD)) cal_link_asserts_i (.mclk(mclk), .rstn(rstn),
		.cal_mode_field(link.cal_mode_field), .mode_write(link.mode_write), .coef_write(link.coef_write),
		.sync_n(link.sync_n), .conversion_done_n(link.conversion_done_n), .result(link.result));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task final_report;
		if (fails == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task check(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("BAD %0t: got %h expected %h", $time, got, exp);
			fails++;
		end
	endtask
	task hang;
		$display("BAD %0t: wait ran out", $time);
		fails++;
		final_report();
	endtask
	task tick(input int k);
		repeat (k) @(posedge mclk);
		#2;
	endtask
	task automatic issue(input logic [2:0] m);
		mode_in = m;
		start = 1'b1;
		tick(1);
		start = 1'b0;
	endtask
	// the device lowers ready only once the whole sequence is over
	task automatic run_cal(input logic [2:0] m);
		int i;
		issue(m);
		check({23'h0, busy}, 24'h1);
		{saw_z, saw_r, saw_h} = 3'h0;
		for (i = 0; i < 4000 && cal_done !== 1'b1; i++) begin
			saw_z |= sel_zero_node;
			saw_r |= sel_ref_node;
			if (i < cal_pkg::MOD_DIV + 2) saw_h |= link.conversion_done_n;
			tick(1);
		end
		if (i == 4000) hang();
	endtask
	task automatic next_dv(output int k);
		for (k = 1; k <= 8 * OD; k++) begin
			tick(1);
			if (data_valid === 1'b1) return;
		end
		hang();
	endtask
	task done_low;
		check({23'h0, link.conversion_done_n}, 24'h0);
	endtask
	task t_reset;
		check(offset_coef, cal_pkg::OFFSET_RST);
		check(gain_coef, cal_pkg::GAIN_RST);
		check({23'h0, link.conversion_done_n}, 24'h1);
	endtask
	task t_self;
		gain_sel = 3'h5;
		run_cal(cal_pkg::MODE_SELF);
		check({22'h0, saw_z, saw_r}, 24'h3);
		check({21'h0, cal_gain}, 24'h5);
		check({23'h0, saw_h}, 24'h1);
		done_low();
	endtask
	task t_system;
		run_cal(cal_pkg::MODE_SYS_ZS);
		done_low();
		analog_input = 24'hE00000;
		run_cal(cal_pkg::MODE_SYS_FS);
		done_low();
		g = gain_coef;
		analog_input = 24'h000200;
		run_cal(cal_pkg::MODE_SYS_ZS);
		check(gain_coef, g);
		run_cal(cal_pkg::MODE_SYS_OF);
		done_low();
	endtask
	task automatic load(input logic [23:0] o, input logic [23:0] gn);
		{offset_in, gain_in} = {o, gn};
		load_req = 1'b1;
		tick(1);
		load_req = 1'b0;
		tick(4);
		check(offset_coef, o);
		check(gain_coef, gn);
		next_dv(n);
		next_dv(n);
	endtask
	task t_math;
		analog_input = 24'h3000FF;
		load(24'h100000, 24'h400000);
		check(data_out, 24'h2000FF);
		check(n[23:0], OD);
		load(24'h100000, 24'h800000);
		check(data_out, 24'h4001FE);
		word24 = 1'b0;
		next_dv(n);
		next_dv(n);
		check({16'h0, data_out[7:0]}, 24'h0);
		word24 = 1'b1;
		bipolar = 1'b1;
		load(24'h100000, 24'h400000);
		check(data_out, 24'hA000FF);
		bipolar = 1'b0;
	endtask
	// sync held low a few cycles, output must restart a full period later
	task t_sync;
		next_dv(n);
		sync_req = 1'b1;
		tick(4);
		sync_req = 1'b0;
		next_dv(n);
		check(n[23:0], OD);
	endtask
	task t_bg;
		issue(cal_pkg::MODE_BG);
		next_dv(n);
		next_dv(n);
		next_dv(n);
		check(n[23:0], 6 * OD);
	endtask
	initial begin
		{rstn, start, sync_req, load_req, bipolar, word24} = 6'h01;
		{mode_in, gain_sel} = 6'h00;
		{offset_in, gain_in} = 48'h0;
		analog_input = 24'h000100;
		ref_sample = 24'hC00000;
		zero_sample = 24'h000010;
		{fails, num_checks} = 0;
		repeat (20) @(posedge mclk);
		#2;
		rstn = 1'b1;
		tick(1);
		t_reset();
		t_self();
		t_system();
		t_math();
		t_sync();
		t_bg();
		final_report();
	end
endmodule
